/* File: aar_pkg.sv */
// constants and types for the auto-negotiation ability register pair
// assumes a single 25 MHz clock domain and a synchronous, active high reset
package aar_pkg;
   typedef logic [15:0] aar_word_t;
   typedef logic [4:0]  aar_addr_t;
   typedef logic [3:0]  aar_strap_t;

   // register numbers on the management port
   localparam aar_addr_t ADV_ADDR = 5'h04;
   localparam aar_addr_t LP_ADDR  = 5'h05;

   // field positions, shared by both words
   localparam int NP_BIT     = 15;
   localparam int ACK_BIT    = 14;
   localparam int RF_BIT     = 13;
   localparam int RSV12_BIT  = 12;
   localparam int ASYM_BIT   = 11;
   localparam int PAUSE_BIT  = 10;
   localparam int T4_BIT     = 9;
   localparam int TECH_HI    = 8;
   localparam int TECH_LO    = 5;
   localparam int SEL_HI     = 4;

   // values after reset; strap bits 8:5 are merged in at reset
   localparam aar_word_t ADV_RST_FIXED = 16'h0401;
   localparam aar_word_t LP_RST        = 16'h0000;
   localparam logic [4:0] SEL_IEEE     = 5'h01;

   // writable bits of the advertisement, loadable bits of the partner word
   localparam aar_word_t ADV_WR_MASK = 16'hAFFF;
   localparam aar_word_t LP_RX_MASK  = 16'hAFFF;
endpackage

/* File: aar_sync2.sv */
// two-stage synchroniser for the strap pins
// assumes the straps are quasi-static and held for at least three clocks of reset
module aar_sync2 (
   // clock
   input  logic                REF_CLK,
   // pins and synchronised copy
   input  aar_pkg::aar_strap_t din,
   output aar_pkg::aar_strap_t dout
);
   import aar_pkg::*;

   typedef struct packed {
      aar_strap_t s1;
      aar_strap_t s2;
   } aar_sync_st_t;

   aar_sync_st_t st_r;
   aar_sync_st_t st_nxt;

   // no reset: it must keep running while reset is held so the straps are caught
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge REF_CLK) begin
      st_r <= st_nxt;
   end

   assign dout = st_r.s2;
endmodule

/* File: aar_lp_reg.sv */
// holder of the link partner ability word received by auto-negotiation
// assumes the negotiation engine on the same clock gives one-cycle pulses
module aar_lp_reg (
   // clock and reset
   input  logic               REF_CLK,
   input  logic               RST,
   // events from the negotiation engine
   input  logic               restart,
   input  logic               rx_valid,
   input  aar_pkg::aar_word_t rx_word,
   input  logic               ack_set,
   // held word
   output aar_pkg::aar_word_t word
);
   import aar_pkg::*;

   typedef struct packed {
      aar_word_t word;
   } aar_lp_st_t;

   aar_lp_st_t st_r;
   aar_lp_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (restart) begin
         st_nxt.word = LP_RST; // RULE18
      end
      // a received word or acknowledge in the restart cycle is kept
      if (rx_valid) begin
         st_nxt.word = (rx_word & LP_RX_MASK) | (st_nxt.word & ~LP_RX_MASK); // RULE12 RULE14 RULE16 RULE17
      end
      if (ack_set) begin
         st_nxt.word[ACK_BIT] = 1'b1; // RULE13
      end
      if (RST) begin
         st_nxt.word = LP_RST; // RULE15 RULE16
      end
   end

   always_ff @(posedge REF_CLK) begin
      st_r <= st_nxt;
   end

   assign word = st_r.word;
endmodule

/* File: aar_top.sv */
// local advertisement and link partner ability registers of a 10/100 transceiver
// assumes a parallel management port from a frame decoder on the same clock,
// an auto-negotiation engine on the same clock, and strap pins from outside

// Functional notes
// [RULE1] advert bit 15 next page, RW, resets zero
// [RULE2] advert bit 13 remote fault, RW, resets zero
// [RULE3] advert bit 11 asymmetric pause, RW, resets zero
// [RULE4] advert bit 10 pause, RW, resets one
// [RULE5] advert bits 9:5 gate abilities sent out
// [RULE6] advert bits 8:5 default from reset straps
// [RULE7] reset restores every advert default
// [RULE8] advert reads return last written value
// [RULE9] software never sets advert bit 9
// [RULE10] advert selector resets to 00001
// [RULE11] reserved bits 14, 12 read zero
// [RULE12] partner bit 15 next page, read-only
// [RULE13] partner bit 14 set on acknowledge
// [RULE14] partner bit 13 copies partner remote fault
// [RULE15] partner pause bits 11:10 read-only, reset zero
// [RULE16] partner technology bits 9:5 read-only, reset zero
// [RULE17] partner selector 4:0 read-only, bit 12 zero
// [RULE18] restart or reset clears partner fields
// [RULE19] software trusts partner word after negotiation completes
// [RULE20] advert word sent as base code word
module aar_top (
   // clock and reset
   input  logic                REF_CLK,
   input  logic                RST,
   // strap pins for the technology defaults
   input  aar_pkg::aar_strap_t STRAP_ABIL,
   // management register port
   input  aar_pkg::aar_addr_t  MGMT_ADDR,
   input  logic                MGMT_WR,
   input  logic                MGMT_RD,
   input  aar_pkg::aar_word_t  MGMT_WDATA,
   output aar_pkg::aar_word_t  MGMT_RDATA,
   output logic                MGMT_RVALID,
   // auto-negotiation engine
   input  logic                AN_RESTART,
   input  logic                LCW_RX_VALID,
   input  aar_pkg::aar_word_t  LCW_RX_WORD,
   input  logic                LCW_ACK_SET,
   output aar_pkg::aar_word_t  ADV_WORD,
   output aar_pkg::aar_word_t  LP_WORD
);
   import aar_pkg::*;

   typedef struct packed {
      aar_word_t adv;
      aar_word_t rdata;
      logic      rvalid;
   } aar_top_st_t;

   aar_top_st_t st_r;
   aar_top_st_t st_nxt;
   aar_strap_t  strap_s;
   aar_word_t   lp_word;
   aar_word_t   adv_dflt;
   logic        adv_wr;

   aar_sync2 u_sync (
      .REF_CLK (REF_CLK),
      .din     (STRAP_ABIL),
      .dout    (strap_s)
   );

   aar_lp_reg u_lp (
      .REF_CLK  (REF_CLK),
      .RST      (RST),
      .restart  (AN_RESTART),
      .rx_valid (LCW_RX_VALID),
      .rx_word  (LCW_RX_WORD),
      .ack_set  (LCW_ACK_SET),
      .word     (lp_word)
   );

   // strap value is whatever the synchroniser holds at the last reset edge
   assign adv_dflt = ADV_RST_FIXED | (aar_word_t'(strap_s) << TECH_LO); // RULE6
   assign adv_wr   = MGMT_WR && (MGMT_ADDR == ADV_ADDR);

   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = MGMT_RD;
      if (MGMT_RD) begin
         case (MGMT_ADDR)
            ADV_ADDR: st_nxt.rdata = st_r.adv; // RULE8
            LP_ADDR:  st_nxt.rdata = lp_word;  // RULE17
            default:  st_nxt.rdata = '0;
         endcase
      end
      // reserved bits stay zero because they are outside the mask
      if (adv_wr) begin
         st_nxt.adv = (MGMT_WDATA & ADV_WR_MASK) | (st_r.adv & ~ADV_WR_MASK); // RULE1 RULE2 RULE3 RULE5 RULE11
      end
      if (RST) begin
         st_nxt.adv    = adv_dflt; // RULE4 RULE7 RULE10
         st_nxt.rdata  = '0;
         st_nxt.rvalid = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      st_r <= st_nxt;
   end

   // pause and remote fault leave the block only inside this word and in advertisement reads on MGMT_RDATA
   assign ADV_WORD    = st_r.adv; // RULE20
   assign LP_WORD     = lp_word;
   assign MGMT_RDATA  = st_r.rdata;
   assign MGMT_RVALID = st_r.rvalid;

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   property p_next_page;
      adv_wr |=> ADV_WORD[NP_BIT] == $past(MGMT_WDATA[NP_BIT]);
   endproperty
   a_next_page: assert property (p_next_page) // RULE1
      else $error("next page bit did not take the written value");

   property p_rfault;
      adv_wr ##1 !adv_wr [*2]
         |-> ADV_WORD[RF_BIT] == $past(MGMT_WDATA[RF_BIT], 2);
   endproperty
   a_rfault: assert property (p_rfault) // RULE2
      else $error("remote fault bit lost its written value");

   property p_asym;
      adv_wr |=> ADV_WORD[ASYM_BIT] == $past(MGMT_WDATA[ASYM_BIT]);
   endproperty
   a_asym: assert property (p_asym) // RULE3
      else $error("asymmetric pause bit did not take the written value");

   property p_pause_rst;
      $fell(RST) |-> ADV_WORD[PAUSE_BIT] == 1'b1;
   endproperty
   a_pause_rst: assert property (p_pause_rst) // RULE4
      else $error("pause bit not one after reset");

   property p_tech;
      adv_wr |=> ADV_WORD[T4_BIT:TECH_LO] == $past(MGMT_WDATA[T4_BIT:TECH_LO]);
   endproperty
   a_tech: assert property (p_tech) // RULE5
      else $error("technology bits did not take the written value");

   property p_strap;
      $fell(RST) |-> ADV_WORD[TECH_HI:TECH_LO] == $past(strap_s);
   endproperty
   a_strap: assert property (p_strap) // RULE6
      else $error("technology defaults differ from the straps");

   property p_rst_dflt;
      $fell(RST) |-> ADV_WORD[NP_BIT:ASYM_BIT] == 5'h00 && ADV_WORD[T4_BIT] == 1'b0;
   endproperty
   a_rst_dflt: assert property (p_rst_dflt) // RULE7
      else $error("advertisement not at defaults after reset");

   property p_read_adv;
      MGMT_RD && MGMT_ADDR == ADV_ADDR
         |=> MGMT_RVALID && MGMT_RDATA == $past(ADV_WORD);
   endproperty
   a_read_adv: assert property (p_read_adv) // RULE8
      else $error("advertisement read returned a wrong value");

   property p_sel_rst;
      $fell(RST) |-> ADV_WORD[SEL_HI:0] == SEL_IEEE;
   endproperty
   a_sel_rst: assert property (p_sel_rst) // RULE10
      else $error("selector not 00001 after reset");

   property p_rsvd;
      MGMT_RVALID |-> MGMT_RDATA[RSV12_BIT] == 1'b0
         && (MGMT_RDATA[ACK_BIT] == 1'b0 || $past(MGMT_ADDR) == LP_ADDR);
   endproperty
   a_rsvd: assert property (p_rsvd) // RULE11
      else $error("reserved bit read as one");

   property p_lp_np;
      LCW_RX_VALID && !AN_RESTART |=> LP_WORD[NP_BIT] == $past(LCW_RX_WORD[NP_BIT]);
   endproperty
   a_lp_np: assert property (p_lp_np) // RULE12
      else $error("partner next page not copied");

   property p_lp_ack;
      LCW_ACK_SET |=> LP_WORD[ACK_BIT] ##1 (LP_WORD[ACK_BIT] || $past(AN_RESTART));
   endproperty
   a_lp_ack: assert property (p_lp_ack) // RULE13
      else $error("partner acknowledge not set");

   property p_lp_rf;
      LCW_RX_VALID |=> LP_WORD[RF_BIT] == $past(LCW_RX_WORD[RF_BIT])
         && ($past(adv_wr) || ADV_WORD == $past(ADV_WORD));
   endproperty
   a_lp_rf: assert property (p_lp_rf) // RULE14
      else $error("partner remote fault not copied or acted upon");

   property p_lp_pause;
      LCW_RX_VALID |=> LP_WORD[ASYM_BIT:PAUSE_BIT] == $past(LCW_RX_WORD[ASYM_BIT:PAUSE_BIT]);
   endproperty
   a_lp_pause: assert property (p_lp_pause) // RULE15
      else $error("partner pause bits not copied");

   property p_lp_tech;
      LCW_RX_VALID |=> LP_WORD[T4_BIT:TECH_LO] == $past(LCW_RX_WORD[T4_BIT:TECH_LO]);
   endproperty
   a_lp_tech: assert property (p_lp_tech) // RULE16
      else $error("partner technology bits not copied");

   property p_lp_sel;
      LCW_RX_VALID |=> LP_WORD[SEL_HI:0] == $past(LCW_RX_WORD[SEL_HI:0])
         && LP_WORD[RSV12_BIT] == 1'b0;
   endproperty
   a_lp_sel: assert property (p_lp_sel) // RULE17
      else $error("partner selector wrong or reserved bit set");

   property p_lp_restart;
      AN_RESTART && !LCW_RX_VALID |=> LP_WORD[T4_BIT:0] == 10'h000;
   endproperty
   a_lp_restart: assert property (p_lp_restart) // RULE18
      else $error("partner fields not cleared by restart");

   property p_adv_out;
      MGMT_RD && MGMT_ADDR == ADV_ADDR && !adv_wr ##1 !adv_wr
         |-> MGMT_RDATA == ADV_WORD;
   endproperty
   a_adv_out: assert property (p_adv_out) // RULE20
      else $error("sent word differs from the advertisement register");

   // management port answers and holds
   property p_rvalid;
      !$past(RST) |-> MGMT_RVALID == $past(MGMT_RD);
   endproperty
   a_rvalid: assert property (p_rvalid) // RULE8
      else $error("read answer valid not one cycle after the strobe");

   property p_read_lp;
      MGMT_RD && MGMT_ADDR == LP_ADDR |=> MGMT_RDATA == $past(LP_WORD);
   endproperty
   a_read_lp: assert property (p_read_lp) // RULE17
      else $error("partner read returned a wrong value");

   property p_read_other;
      MGMT_RD && MGMT_ADDR != ADV_ADDR && MGMT_ADDR != LP_ADDR
         |=> MGMT_RDATA == 16'h0000;
   endproperty
   a_read_other: assert property (p_read_other) // RULE8
      else $error("unmapped read returned nonzero data");

   property p_rdata_hold;
      !MGMT_RD |=> $stable(MGMT_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) // RULE8
      else $error("read data changed without a read");

   property p_wr_ignored;
      MGMT_WR && MGMT_ADDR != ADV_ADDR
         |=> ADV_WORD == $past(ADV_WORD);
   endproperty
   a_wr_ignored: assert property (p_wr_ignored) // RULE8
      else $error("write to another register changed the advertisement");

   property p_adv_hold;
      !adv_wr |=> ADV_WORD == $past(ADV_WORD);
   endproperty
   a_adv_hold: assert property (p_adv_hold) // RULE8
      else $error("advertisement changed without a write");

   property p_adv_rsvd;
      ADV_WORD[ACK_BIT] == 1'b0 && ADV_WORD[RSV12_BIT] == 1'b0;
   endproperty
   a_adv_rsvd: assert property (p_adv_rsvd) // RULE11
      else $error("reserved advertisement bit set");

   property p_pause_wr;
      adv_wr |=> ADV_WORD[PAUSE_BIT] == $past(MGMT_WDATA[PAUSE_BIT]);
   endproperty
   a_pause_wr: assert property (p_pause_wr) // RULE4
      else $error("pause bit did not take the written value");

   property p_sel_wr;
      adv_wr |=> ADV_WORD[SEL_HI:0] == $past(MGMT_WDATA[SEL_HI:0]);
   endproperty
   a_sel_wr: assert property (p_sel_wr) // RULE10
      else $error("selector did not take the written value");

   property p_np_rst;
      $fell(RST) |-> ADV_WORD[NP_BIT] == 1'b0;
   endproperty
   a_np_rst: assert property (p_np_rst) // RULE1
      else $error("next page bit not zero after reset");

   property p_rf_rst;
      $fell(RST) |-> ADV_WORD[RF_BIT] == 1'b0;
   endproperty
   a_rf_rst: assert property (p_rf_rst) // RULE2
      else $error("remote fault bit not cleared by reset");

   property p_asym_rst;
      $fell(RST) |-> ADV_WORD[ASYM_BIT] == 1'b0;
   endproperty
   a_asym_rst: assert property (p_asym_rst) // RULE3
      else $error("asymmetric pause bit not zero after reset");

   property p_rdata_rst;
      $fell(RST) |-> MGMT_RDATA == 16'h0000 && !MGMT_RVALID;
   endproperty
   a_rdata_rst: assert property (p_rdata_rst) // RULE7
      else $error("read port not idle after reset");

   // partner word: read-only, cleared as a whole on restart
   property p_lp_rst;
      $fell(RST) |-> LP_WORD == LP_RST;
   endproperty
   a_lp_rst: assert property (p_lp_rst) // RULE15
      else $error("partner word not zero after reset");

   property p_lp_rsvd12;
      LP_WORD[RSV12_BIT] == 1'b0;
   endproperty
   a_lp_rsvd12: assert property (p_lp_rsvd12) // RULE17
      else $error("partner reserved bit set");

   property p_lp_hold;
      !AN_RESTART && !LCW_RX_VALID && !LCW_ACK_SET
         |=> LP_WORD == $past(LP_WORD);
   endproperty
   a_lp_hold: assert property (p_lp_hold) // RULE12
      else $error("partner word changed without an engine event");

   property p_lp_ack_keep;
      LCW_RX_VALID && !AN_RESTART && !LCW_ACK_SET
         |=> LP_WORD[ACK_BIT] == $past(LP_WORD[ACK_BIT]);
   endproperty
   a_lp_ack_keep: assert property (p_lp_ack_keep) // RULE13
      else $error("received word altered the acknowledge bit");

   property p_lp_clear_all;
      AN_RESTART && !LCW_RX_VALID && !LCW_ACK_SET
         |=> LP_WORD == LP_RST;
   endproperty
   a_lp_clear_all: assert property (p_lp_clear_all) // RULE18
      else $error("restart left partner bits set");

   c_write_read: cover property (adv_wr ##[1:2] MGMT_RD && MGMT_ADDR == ADV_ADDR);
   c_lp_clear: cover property (AN_RESTART && !LCW_RX_VALID);
   c_lp_read: cover property (LCW_RX_VALID ##[1:4] MGMT_RD && MGMT_ADDR == LP_ADDR);
   c_restart: cover property (LCW_RX_VALID ##[1:8] AN_RESTART);
   c_ack: cover property (LCW_ACK_SET && LCW_RX_VALID);
endmodule

/* File: aar_mgmt_model.sv */
// management master model for the ability register pair
// assumes the block takes strobes on the rising edge; drives at falling edges
module aar_mgmt_model (
   // clock
   input  logic               REF_CLK,
   // read answer
   input  aar_pkg::aar_word_t MGMT_RDATA,
   input  logic               MGMT_RVALID,
   // request
   output aar_pkg::aar_addr_t MGMT_ADDR,
   output logic               MGMT_WR,
   output logic               MGMT_RD,
   output aar_pkg::aar_word_t MGMT_WDATA
);
   timeunit 1ns;
   timeprecision 1ps;
   import aar_pkg::*;

   initial begin
      MGMT_ADDR = 5'h00;
      MGMT_WR = 1'h0;
      MGMT_RD = 1'h0;
      MGMT_WDATA = 16'h0000;
   end

   task automatic wr(input aar_addr_t a, input aar_word_t d);
      @(negedge REF_CLK);
      MGMT_ADDR = a;
      MGMT_WDATA = d & 16'hFDFF;
      MGMT_WR = 1'h1;
      @(negedge REF_CLK);
      MGMT_WR = 1'h0;
      // released data must not look like a held value
      MGMT_WDATA = ~MGMT_WDATA;
   endtask

   task automatic rd(input aar_addr_t a, output aar_word_t d, output logic ok);
      @(negedge REF_CLK);
      MGMT_ADDR = a;
      MGMT_RD = 1'h1;
      @(negedge REF_CLK);
      MGMT_RD = 1'h0;
      ok = MGMT_RVALID;
      d = MGMT_RDATA;
   endtask
endmodule

/* File: aar_top_tb.sv */
// self-checking bench for the ability register pair
// assumes the management model above and a bench-driven negotiation engine
module aar_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import aar_pkg::*;

   typedef struct packed {
      aar_addr_t wa;
      aar_word_t wd;
      aar_addr_t ra;
      aar_word_t ex;
   } aar_row_t;

   // write row then read row; bit 9 never set by software
   localparam aar_row_t ROWS [6] = '{
      '{5'h04, 16'hFFFF, 5'h04, 16'hADFF},
      '{5'h04, 16'h0000, 5'h04, 16'h0000},
      '{5'h04, 16'h8000, 5'h04, 16'h8000},
      '{5'h05, 16'h1234, 5'h05, 16'h0000},
      '{5'h03, 16'hFFFF, 5'h03, 16'h0000},
      '{5'h04, 16'h2541, 5'h04, 16'h2541}};

   logic       REF_CLK = 1'h0;
   logic       RST = 1'h1;
   logic       AN_RESTART = 1'h0;
   logic       LCW_RX_VALID = 1'h0;
   logic       LCW_ACK_SET = 1'h0;
   aar_strap_t STRAP_ABIL = 4'h5;
   aar_word_t  LCW_RX_WORD = 16'h0000;
   aar_word_t  MGMT_RDATA;
   aar_word_t  MGMT_WDATA;
   aar_word_t  ADV_WORD;
   aar_word_t  LP_WORD;
   aar_word_t  rd_d;
   aar_addr_t  MGMT_ADDR;
   logic       MGMT_WR;
   logic       MGMT_RD;
   logic       MGMT_RVALID;
   logic       rd_ok;
   int         fails = 0;
   int         checked = 0;

   always #20 REF_CLK = ~REF_CLK;

   aar_top DUT (.REF_CLK(REF_CLK), .RST(RST), .STRAP_ABIL(STRAP_ABIL),
      .MGMT_ADDR(MGMT_ADDR), .MGMT_WR(MGMT_WR), .MGMT_RD(MGMT_RD),
      .MGMT_WDATA(MGMT_WDATA), .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
      .AN_RESTART(AN_RESTART), .LCW_RX_VALID(LCW_RX_VALID),
      .LCW_RX_WORD(LCW_RX_WORD), .LCW_ACK_SET(LCW_ACK_SET),
      .ADV_WORD(ADV_WORD), .LP_WORD(LP_WORD));

   aar_mgmt_model mm (.REF_CLK(REF_CLK), .MGMT_RDATA(MGMT_RDATA),
      .MGMT_RVALID(MGMT_RVALID), .MGMT_ADDR(MGMT_ADDR), .MGMT_WR(MGMT_WR),
      .MGMT_RD(MGMT_RD), .MGMT_WDATA(MGMT_WDATA));

   task automatic chk(input aar_word_t got, input aar_word_t exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input aar_addr_t a, input aar_word_t exp);
      mm.rd(a, rd_d, rd_ok);
      chk({15'h0000, rd_ok}, 16'h0001);
      chk(rd_d, exp);
   endtask

   task automatic do_reset(input aar_strap_t s);
      STRAP_ABIL = s;
      RST = 1'h1;
      repeat (10) @(negedge REF_CLK);
      RST = 1'h0;
   endtask

   // one-cycle engine pulses
   task automatic lcw(input logic rs, input logic v, input logic a, input aar_word_t w);
      @(negedge REF_CLK);
      AN_RESTART = rs;
      LCW_RX_VALID = v;
      LCW_ACK_SET = a;
      LCW_RX_WORD = w;
      @(negedge REF_CLK);
      AN_RESTART = 1'h0;
      LCW_RX_VALID = 1'h0;
      LCW_ACK_SET = 1'h0;
      LCW_RX_WORD = ~w;
   endtask

   task automatic close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      do_reset(4'h5);
      chk(ADV_WORD, 16'h04A1);
      foreach (ROWS[i]) begin
         mm.wr(ROWS[i].wa, ROWS[i].wd);
         rd_chk(ROWS[i].ra, ROWS[i].ex);
      end
      chk(ADV_WORD, 16'h2541);
      do_reset(4'hA);
      chk(ADV_WORD, 16'h0541);
      rd_chk(ADV_ADDR, 16'h0541);
      chk(LP_WORD, 16'h0000);
      lcw(1'h0, 1'h1, 1'h0, 16'hFFFF);
      rd_chk(LP_ADDR, 16'hAFFF);
      lcw(1'h0, 1'h0, 1'h1, 16'h0000);
      chk(LP_WORD, 16'hEFFF);
      // restart and a new word in one cycle: word lands on a cleared register
      lcw(1'h1, 1'h1, 1'h0, 16'h2021);
      chk(LP_WORD, 16'h2021);
      lcw(1'h1, 1'h0, 1'h0, 16'h0000);
      chk(LP_WORD, 16'h0000);
      // word and acknowledge in one cycle: both land
      lcw(1'h0, 1'h1, 1'h1, 16'h8000);
      chk(LP_WORD, 16'hC000);
      close_out();
   end

   // whole run is under 200 cycles
   initial begin
      repeat (1000) @(posedge REF_CLK);
      fails++;
      close_out();
   end
endmodule
